// ---- rtl/usb3_pipe_phy_cfg.svh ----
// Timing counts, codes, offsets and reset values of the PIPE transceiver logic
`ifndef USB3_PIPE_PHY_CFG_SVH
`define USB3_PIPE_PHY_CFG_SVH
`define CLK_PERIOD_NS    100
`define PCLK_STABLE_NS   2000
`define PCLK_STABLE_CYC  ((`PCLK_STABLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWR_TRANS_NS     500
`define PWR_TRANS_CYC    ((`PWR_TRANS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RX_DETECT_NS     1000
`define RX_DETECT_CYC    ((`RX_DETECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWR_P0           2'b00
`define PWR_P1           2'b01
`define PWR_P2           2'b10
`define PWR_P3           2'b11
`define RXST_OK          3'b000
`define RXST_SKP_ADD     3'b001
`define RXST_SKP_DEL     3'b010
`define RXST_DETECTED    3'b011
`define RXST_DECODE      3'b100
`define RXST_OVERFLOW    3'b101
`define RXST_UNDERFLOW   3'b110
`define RXST_DISPARITY   3'b111
`define SKP_WORD         32'h3C3C_3C3C
`define SKP_FLAGS        4'hF
`define EB_FULL          4'h8
`define EB_HIGH          4'h6
`define EB_LOW           4'h2
`define EB_START         4'h4
`define OZ_RUN_WORDS     3'h4
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define CTRL_RESET       32'h0000_0001
`define CTRL_SKP_EN_BIT  0
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// ---- rtl/usb3_pipe_phy_pkg.sv ----
// Types of the PIPE transceiver logic
package usb3_pipe_phy_pkg;
   typedef enum logic [1:0] {st_stable, st_ready, st_trans, st_detect} fsm_type;
   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  flags;
      logic        dec_err;
      logic        disp_err;
   } entry_type;
   typedef struct packed {
      fsm_type        fsm;
      logic [7:0]     cnt;
      logic [1:0]     power;
      logic [1:0]     target;
      logic           req_prev;
      logic           loopback;
      logic [3:0]     s1;
      logic [3:0]     s2;
      entry_type [7:0] eb;
      logic [2:0]     wr;
      logic [2:0]     rd;
      logic [3:0]     fill;
      logic           rx_run;
      logic [31:0]    rx_word;
      logic [3:0]     rx_flags;
      logic           rx_valid;
      logic [2:0]     rx_status;
      logic           phy_status;
      logic           pclk;
      logic           rx_idle;
      logic           pwr_present;
      logic           rx_term;
      logic [31:0]    tx_word;
      logic [3:0]     tx_flags;
      logic           tx_idle;
      logic           tx_lfps;
      logic [2:0]     oz_cnt;
      logic           oz_phase;
      logic           aw_got;
      logic           w_got;
      logic [7:0]     awaddr;
      logic [31:0]    wdata;
      logic [3:0]     wstrb;
      logic           awready;
      logic           wready;
      logic           bvalid;
      logic [1:0]     bresp;
      logic           arready;
      logic           rvalid;
      logic [31:0]    rdata;
      logic [1:0]     rresp;
      logic [31:0]    ctrl;
   } state_type;
endpackage : usb3_pipe_phy_pkg

// ---- rtl/usb3_pipe_phy_interface.sv ----
// PIPE transceiver logic: power states, detection, elastic buffer, loopback
`timescale 1ns/1ns
`default_nettype none
`include "usb3_pipe_phy_cfg.svh"

module usb3_pipe_phy_interface (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ref_clk,
   input  wire logic [31:0] tx_symbol_word,
   input  wire logic [3:0]  tx_control_flags,
   input  wire logic        detect_or_loopback_request,
   input  wire logic        tx_elec_idle,
   input  wire logic        rx_polarity,
   input  wire logic        rx_eq_training,
   input  wire logic        rx_termination,
   input  wire logic        tx_ones_zeros,
   input  wire logic [1:0]  power_down,
   input  wire logic [31:0] ser_rx_word,
   input  wire logic [3:0]  ser_rx_flags,
   input  wire logic        ser_rx_valid,
   input  wire logic        ser_rx_decode_err,
   input  wire logic        ser_rx_disp_err,
   input  wire logic        line_rx_present,
   input  wire logic        line_elec_idle,
   input  wire logic        vbus_sense,
   output logic             pclk,
   output logic [31:0]      rx_symbol_word,
   output logic [3:0]       rx_control_flags,
   output logic             rx_word_valid,
   output logic [2:0]       rx_status,
   output logic             phy_status,
   output logic             rx_elec_idle,
   output logic             power_present,
   output logic [31:0]      ser_tx_word,
   output logic [3:0]       ser_tx_flags,
   output logic             ser_tx_idle,
   output logic             ser_tx_lfps,
   output logic             ser_loopback,
   output logic             ser_rx_term,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   usb3_pipe_phy_pkg::state_type s;
   usb3_pipe_phy_pkg::state_type n;
   usb3_pipe_phy_pkg::entry_type head;
   usb3_pipe_phy_pkg::entry_type inw;
   logic       wr_en;
   logic       rd_en;
   logic       out_valid;
   logic       is_skp;
   logic       skp_en;
   logic       skp_ind;
   logic       err_ind;
   logic       det_done;
   logic [2:0] eb_code;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      n = s;
      // Pins from other domains
      n.s1 = {ref_clk, line_rx_present, line_elec_idle, vbus_sense};
      n.s2 = s.s1;
      n.pclk = s.s2[3] && s.power != `PWR_P3 && s.fsm != usb3_pipe_phy_pkg::st_stable;
      n.rx_idle = s.s2[1];
      n.pwr_present = s.s2[0];
      n.rx_term = rx_termination;
      n.req_prev = detect_or_loopback_request;
      n.phy_status = 1'b0;
      det_done = 1'b0;
      skp_en = s.ctrl[`CTRL_SKP_EN_BIT];

      case (s.fsm)
         usb3_pipe_phy_pkg::st_stable: begin
            n.cnt = s.cnt + 8'd1;
            if (s.cnt == 8'(`PCLK_STABLE_CYC - 1)) begin
               n.fsm = usb3_pipe_phy_pkg::st_ready;
               n.cnt = 8'd0;
               n.phy_status = 1'b1;
            end
         end
         usb3_pipe_phy_pkg::st_ready: begin
            if (power_down != s.power) begin
               n.fsm = usb3_pipe_phy_pkg::st_trans;
               n.target = power_down;
               n.cnt = 8'd0;
            end else if (detect_or_loopback_request && !s.req_prev && s.power[1]) begin
               n.fsm = usb3_pipe_phy_pkg::st_detect;
               n.cnt = 8'd0;
            end
         end
         usb3_pipe_phy_pkg::st_trans: begin
            n.cnt = s.cnt + 8'd1;
            if (s.cnt == 8'(`PWR_TRANS_CYC - 1)) begin
               n.fsm = usb3_pipe_phy_pkg::st_ready;
               n.cnt = 8'd0;
               n.power = s.target;
               n.phy_status = s.target != `PWR_P3;
            end
         end
         usb3_pipe_phy_pkg::st_detect: begin
            n.cnt = s.cnt + 8'd1;
            if (s.cnt == 8'(`RX_DETECT_CYC - 1)) begin
               n.fsm = usb3_pipe_phy_pkg::st_ready;
               n.cnt = 8'd0;
               n.phy_status = 1'b1;
               det_done = 1'b1;
            end
         end
         default: begin
            n.fsm = usb3_pipe_phy_pkg::st_stable;
         end
      endcase

      if (!detect_or_loopback_request) begin
         n.loopback = 1'b0;
      end else if (s.power == `PWR_P0 && !tx_elec_idle
                   && s.fsm == usb3_pipe_phy_pkg::st_ready) begin
         n.loopback = 1'b1;
      end

      inw.data = rx_polarity ? ~ser_rx_word : ser_rx_word;
      inw.flags = ser_rx_flags;
      inw.dec_err = ser_rx_decode_err;
      inw.disp_err = ser_rx_disp_err;

      head = s.eb[s.rd];
      is_skp = head.data == `SKP_WORD && head.flags == `SKP_FLAGS;
      wr_en = ser_rx_valid && s.power == `PWR_P0 && s.fill != `EB_FULL;
      rd_en = 1'b0;
      out_valid = 1'b0;
      skp_ind = 1'b0;
      err_ind = 1'b0;
      eb_code = `RXST_OK;
      if (s.rx_run) begin
         if (s.fill == 4'h0) begin
            n.rx_run = 1'b0;
            eb_code = `RXST_UNDERFLOW;
            err_ind = 1'b1;
         end else if (skp_en && is_skp && s.fill >= `EB_HIGH) begin
            rd_en = 1'b1;
            eb_code = `RXST_SKP_DEL;
            skp_ind = 1'b1;
         end else if (skp_en && is_skp && s.fill <= `EB_LOW) begin
            out_valid = 1'b1;
            eb_code = `RXST_SKP_ADD;
            skp_ind = 1'b1;
         end else begin
            rd_en = 1'b1;
            out_valid = 1'b1;
         end
         if (s.fill != 4'h0 && head.dec_err) begin
            eb_code = `RXST_DECODE;
            err_ind = 1'b1;
         end else if (s.fill != 4'h0 && head.disp_err) begin
            eb_code = `RXST_DISPARITY;
            err_ind = 1'b1;
         end
      end else if (s.fill >= `EB_START) begin
         n.rx_run = 1'b1;
      end
      if (ser_rx_valid && s.power == `PWR_P0 && s.fill == `EB_FULL) begin
         eb_code = `RXST_OVERFLOW;
         err_ind = 1'b1;
      end
      if (wr_en) begin
         n.eb[s.wr] = inw;
         n.wr = s.wr + 3'd1;
      end
      if (rd_en) begin
         n.rd = s.rd + 3'd1;
      end
      n.fill = s.fill + {3'b000, wr_en} - {3'b000, rd_en};

      // receive word out, still delivered in loopback
      n.rx_word = head.data;
      n.rx_flags = head.flags;
      n.rx_valid = out_valid && !rx_eq_training && s.power == `PWR_P0;
      if (det_done) begin
         n.rx_status = s.s2[2] ? `RXST_DETECTED : `RXST_OK;
      end else begin
         n.rx_status = eb_code;
      end

      // ones and zeros runs of 128 bits
      if (tx_ones_zeros) begin
         n.oz_cnt = s.oz_cnt + 3'd1;
         if (s.oz_cnt == `OZ_RUN_WORDS - 3'd1) begin
            n.oz_cnt = 3'd0;
            n.oz_phase = !s.oz_phase;
         end
      end else begin
         n.oz_cnt = 3'd0;
         n.oz_phase = 1'b0;
      end
      if (s.loopback) begin
         n.tx_word = head.data;
         n.tx_flags = head.flags;
      end else if (tx_ones_zeros) begin
         n.tx_word = s.oz_phase ? 32'h0000_0000 : 32'hFFFF_FFFF;
         n.tx_flags = 4'h0;
      end else begin
         n.tx_word = tx_symbol_word;
         n.tx_flags = tx_control_flags;
      end
      // idle forced except in loopback, always idle outside P0
      n.tx_idle = (tx_elec_idle && !s.loopback) || s.power != `PWR_P0;
      n.tx_lfps = detect_or_loopback_request && tx_elec_idle && s.power == `PWR_P0;

      // Register slave, write side
      if (s_axi_awvalid && s.awready) begin
         n.aw_got = 1'b1;
         n.awaddr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s.wready) begin
         n.w_got = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (s.aw_got && s.w_got && !s.bvalid) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `RESP_OKAY;
         if (s.awaddr == `REG_CTRL) begin
            for (int i = 0; i < 4; i++) begin
               if (s.wstrb[i]) begin
                  n.ctrl[8*i +: 8] = s.wdata[8*i +: 8];
               end
            end
         end else if (s.awaddr != `REG_STATUS) begin
            n.bresp = `RESP_SLVERR;
         end
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;
      // Read side
      if (s.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready) begin
         n.rvalid = 1'b1;
         n.rresp = `RESP_OKAY;
         if (s_axi_araddr[7:0] == `REG_CTRL) begin
            n.rdata = s.ctrl;
         end else if (s_axi_araddr[7:0] == `REG_STATUS) begin
            n.rdata = {24'h00_0000, s.fill, s.rx_run, s.loopback, s.power};
         end else begin
            n.rdata = 32'h0000_0000;
            n.rresp = `RESP_SLVERR;
         end
      end
      n.arready = !n.rvalid;
   end

   ////////////////////////////////////////////////////////////////////////////
   // single rising-edge update
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.ctrl <= `CTRL_RESET;
      end else begin
         s <= n;
      end
   end

   assign pclk             = s.pclk;
   assign rx_symbol_word   = s.rx_word;
   assign rx_control_flags = s.rx_flags;
   assign rx_word_valid    = s.rx_valid;
   assign rx_status        = s.rx_status;
   assign phy_status       = s.phy_status;
   assign rx_elec_idle     = s.rx_idle;
   assign power_present    = s.pwr_present;
   assign ser_tx_word      = s.tx_word;
   assign ser_tx_flags     = s.tx_flags;
   assign ser_tx_idle      = s.tx_idle;
   assign ser_tx_lfps      = s.tx_lfps;
   assign ser_loopback     = s.loopback;
   assign ser_rx_term      = s.rx_term;
   assign s_axi_awready    = s.awready;
   assign s_axi_wready     = s.wready;
   assign s_axi_bvalid     = s.bvalid;
   assign s_axi_bresp      = s.bresp;
   assign s_axi_arready    = s.arready;
   assign s_axi_rvalid     = s.rvalid;
   assign s_axi_rdata      = s.rdata;
   assign s_axi_rresp      = s.rresp;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence detect_req_seq;
      s.fsm == usb3_pipe_phy_pkg::st_ready && power_down == s.power
      && detect_or_loopback_request && !s.req_prev && s.power[1];
   endsequence
   sequence detect_end_seq;
      s.fsm == usb3_pipe_phy_pkg::st_detect && s.cnt == 8'(`RX_DETECT_CYC - 1);
   endsequence

   chk_phy_single: assert property (s.phy_status |=> !s.phy_status)
      else $error("phy_status longer than one cycle");
   chk_p3_no_pulse: assert property (s.fsm == usb3_pipe_phy_pkg::st_trans
      && s.target == `PWR_P3 && s.cnt == 8'(`PWR_TRANS_CYC - 1)
      |=> !s.phy_status && s.power == `PWR_P3 ##1 !s.pclk)
      else $error("P3 entry pulsed or kept pclk");
   chk_detect_start: assert property (detect_req_seq |=>
      s.fsm == usb3_pipe_phy_pkg::st_detect [*2])
      else $error("detection not started");
   chk_detect_code: assert property (detect_end_seq |=> s.phy_status
      && s.rx_status == ($past(s.s2[2]) ? `RXST_DETECTED : `RXST_OK))
      else $error("wrong detection result");
   chk_skp_code: assert property (skp_ind && !err_ind && !det_done
      |=> s.rx_status == `RXST_SKP_ADD || s.rx_status == `RXST_SKP_DEL)
      else $error("SKP code missing");
   chk_err_wins: assert property (err_ind && !det_done |=> s.rx_status[2])
      else $error("error code lost");
   chk_loop_end: assert property (!detect_or_loopback_request |=> !s.loopback)
      else $error("loopback kept without request");
   chk_loop_data: assert property (s.loopback |=> s.tx_word == $past(head.data))
      else $error("loopback word not forwarded");
   chk_eq_invalid: assert property (rx_eq_training |=> !s.rx_valid)
      else $error("valid during training");
   chk_tx_idle: assert property (s.power != `PWR_P0 |=> s.tx_idle)
      else $error("transmitter active outside P0");
   chk_oz_pattern: assert property (tx_ones_zeros && !s.loopback
      |=> s.tx_word == 32'hFFFF_FFFF || s.tx_word == 32'h0000_0000)
      else $error("bad ones zeros word");
   chk_stable_pulse: assert property (s.fsm == usb3_pipe_phy_pkg::st_stable
      ##1 s.fsm == usb3_pipe_phy_pkg::st_ready |-> s.phy_status)
      else $error("no clock stable pulse");

endmodule : usb3_pipe_phy_interface
`default_nettype wire

// ---- dv/usb3_serial_side_model.sv ----
// Serial far side: reference clock, deserialised words and line sense signals
`timescale 1ns/1ns
`default_nettype none
module usb3_serial_side_model (
   input  wire logic        aclk,
   output logic             ref_clk,
   output logic [31:0]      ser_rx_word,
   output logic [3:0]       ser_rx_flags,
   output logic             ser_rx_valid,
   output logic             ser_rx_decode_err,
   output logic             ser_rx_disp_err,
   output logic             line_rx_present,
   output logic             line_elec_idle,
   output logic             vbus_sense
);
   initial begin
      ref_clk = 1'b0;
      ser_rx_word = 32'h0000_0000;
      ser_rx_flags = 4'h0;
      ser_rx_valid = 1'b0;
      ser_rx_decode_err = 1'b0;
      ser_rx_disp_err = 1'b0;
      line_rx_present = 1'b0;
      line_elec_idle = 1'b0;
      vbus_sense = 1'b0;
   end
   always #400 ref_clk = ~ref_clk;
   // one data word per cycle, flags from the low nibble
   task send(input logic [31:0] w, input logic [1:0] er);
      @(posedge aclk);
      ser_rx_word <= w;
      ser_rx_flags <= w[3:0];
      ser_rx_valid <= 1'b1;
      ser_rx_decode_err <= er[0];
      ser_rx_disp_err <= er[1];
   endtask : send
   // Line sense levels: receiver present, electrical idle, bus power
   task sense(input logic [2:0] v);
      @(posedge aclk);
      {line_rx_present, line_elec_idle, vbus_sense} <= v;
   endtask : sense
   // Released bus shows the inverse so stale data cannot pass
   task stop();
      @(posedge aclk);
      ser_rx_valid <= 1'b0;
      ser_rx_decode_err <= 1'b0;
      ser_rx_disp_err <= 1'b0;
      ser_rx_word <= ~ser_rx_word;
   endtask : stop
endmodule : usb3_serial_side_model
`default_nettype wire

// ---- dv/tb_usb3_pipe_phy_interface.sv ----
// Self-checking bench of the PIPE transceiver logic
`timescale 1ns/1ns
`default_nettype none
`include "usb3_pipe_phy_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_usb3_pipe_phy_interface;
   logic aclk, aresetn, rq, txi, pol, eqt, term, oz;
   logic [1:0] pd;
   logic [31:0] txw, awaddr, wdata, araddr, rd;
   logic [3:0] txf, wstrb;
   logic awvalid, wvalid, bready, arvalid, rready;
   wire logic ref_clk, sv, sde, sdi, lp, li, vb, pclk, rxv, phs, rxi, pp;
   wire logic stidle, stlfps, slb, sterm, awr, wr, bv, arr, rv;
   wire logic [31:0] sw, rxw, stw, rdata;
   wire logic [3:0] sf, rxf, stf;
   wire logic [2:0] rxs;
   wire logic [1:0] bresp, rresp;
   int mismatches, tests_run, cycles, n;
   logic [1:0] resp;
   usb3_serial_side_model u_usb3_serial_side_model (.aclk(aclk), .ref_clk(ref_clk),
      .ser_rx_word(sw), .ser_rx_flags(sf), .ser_rx_valid(sv), .ser_rx_decode_err(sde),
      .ser_rx_disp_err(sdi), .line_rx_present(lp), .line_elec_idle(li), .vbus_sense(vb));
   usb3_pipe_phy_interface u_usb3_pipe_phy_interface (.aclk(aclk), .aresetn(aresetn),
      .ref_clk(ref_clk), .tx_symbol_word(txw), .tx_control_flags(txf),
      .detect_or_loopback_request(rq), .tx_elec_idle(txi), .rx_polarity(pol),
      .rx_eq_training(eqt), .rx_termination(term), .tx_ones_zeros(oz), .power_down(pd),
      .ser_rx_word(sw), .ser_rx_flags(sf), .ser_rx_valid(sv), .ser_rx_decode_err(sde),
      .ser_rx_disp_err(sdi), .line_rx_present(lp), .line_elec_idle(li), .vbus_sense(vb),
      .pclk(pclk), .rx_symbol_word(rxw), .rx_control_flags(rxf), .rx_word_valid(rxv),
      .rx_status(rxs), .phy_status(phs), .rx_elec_idle(rxi), .power_present(pp),
      .ser_tx_word(stw), .ser_tx_flags(stf), .ser_tx_idle(stidle), .ser_tx_lfps(stlfps),
      .ser_loopback(slb), .ser_rx_term(sterm), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awr), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wr), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arr), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready));
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task final_report();
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   // Hang guard well beyond the whole sequence
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         final_report();
      end
   end
   task axi_wr(input logic [31:0] a, input logic [31:0] d);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} <= {a, 1'b1, d, 4'hF, 1'b1, 1'b1};
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awvalid && awr) begin aw_done = 1'b1; awvalid <= 1'b0; end
         if (wvalid && wr) begin w_done = 1'b1; wvalid <= 1'b0; end
      end
      do @(posedge aclk); while (bv !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task axi_rd(input logic [31:0] a);
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 1'b1, 1'b1};
      do @(posedge aclk); while (arr !== 1'b1);
      arvalid <= 1'b0;
      while (rv !== 1'b1) @(posedge aclk);
      {rd, resp} = {rdata, rresp};
      rready <= 1'b0;
   endtask : axi_rd
   task wait_phy();
      n = 0;
      do begin @(negedge aclk); n++; end while (phs !== 1'b1 && n < 60);
   endtask : wait_phy
   // no new request before the completion pulse
   task set_power(input logic [1:0] p);
      @(posedge aclk);
      pd <= p;
      wait_phy();
      `CHK(n, (p == `PWR_P3) ? 60 : `PWR_TRANS_CYC + 2)
      @(negedge aclk);
      `CHK(phs, 1'b0)
   endtask : set_power
   task detect(input logic present);
      @(posedge aclk);
      rq <= 1'b0;
      u_usb3_serial_side_model.sense({present, 2'b11});
      repeat (4) @(posedge aclk);
      rq <= 1'b1;
      wait_phy();
      `CHK(n, `RX_DETECT_CYC + 2)
      `CHK(rxs, present ? `RXST_DETECTED : `RXST_OK)
      @(negedge aclk);
      `CHK(phs, 1'b0)
      @(posedge aclk);
      rq <= 1'b0;
   endtask : detect
   task rx_burst(input logic p, input logic err, input logic lb, input logic eq);
      logic [31:0] base;
      logic under, dec, seen, dis;
      int k;
      {base, under, dec, seen, dis, k} = {32'h5A17_0000, 4'b0000, 32'd0};
      @(posedge aclk);
      {pol, eqt} <= {p, eq};
      fork
         begin
            for (int i = 0; i < 6; i++) begin
               u_usb3_serial_side_model.send(base + i, {err && i == 4, err && i == 2});
            end
            u_usb3_serial_side_model.stop();
         end
         repeat (30) begin
            @(negedge aclk);
            if (rxv === 1'b1) begin
               `CHK(rxw, p ? ~(base + k) : base + k)
               `CHK(rxf, 4'(k))
               k++;
            end
            if (rxs === `RXST_UNDERFLOW) under = 1'b1;
            if (rxs === `RXST_DECODE) dec = 1'b1;
            if (rxs === `RXST_DISPARITY) dis = 1'b1;
            if (stw[31:16] === base[31:16]) seen = 1'b1;
         end
      join
      @(posedge aclk);
      eqt <= 1'b0;
      `CHK(k, eq ? 0 : 6)
      `CHK(under, 1'b1)
      `CHK(dec, err)
      `CHK(dis, err)
      `CHK(seen, lb)
   endtask : rx_burst
   // request with idle low starts loopback, dropping it ends it
   task loopback();
      @(posedge aclk);
      {rq, txi, txw, txf} <= {1'b1, 1'b0, 32'hA5A5_5A5A, 4'h9};
      repeat (3) @(negedge aclk);
      `CHK(slb, 1'b1)
      rx_burst(1'b0, 1'b0, 1'b1, 1'b0);
      @(posedge aclk);
      rq <= 1'b0;
      repeat (3) @(negedge aclk);
      `CHK(slb, 1'b0)
      `CHK({stw, stf}, {32'hA5A5_5A5A, 4'h9})
   endtask : loopback
   task lfps_idle();
      @(posedge aclk);
      {rq, txi} <= 2'b11;
      repeat (3) @(negedge aclk);
      `CHK({stlfps, stidle, slb}, 3'b110)
      @(posedge aclk);
      {rq, txi} <= 2'b00;
      repeat (3) @(negedge aclk);
      `CHK({stlfps, stidle}, 2'b00)
   endtask : lfps_idle
   task ones_zeros();
      int ones, zeros;
      {ones, zeros} = 0;
      @(posedge aclk);
      oz <= 1'b1;
      repeat (3) @(negedge aclk);
      repeat (8) begin
         @(negedge aclk);
         ones += (stw === 32'hFFFF_FFFF);
         zeros += (stw === 32'h0000_0000);
      end
      `CHK(ones, 4)
      `CHK(zeros, 4)
      @(posedge aclk);
      oz <= 1'b0;
   endtask : ones_zeros
   task regs_and_sense();
      axi_rd(`REG_CTRL);
      `CHK({resp, rd}, {`RESP_OKAY, `CTRL_RESET})
      axi_wr(`REG_CTRL, 32'h0000_00A5);
      axi_rd(`REG_CTRL);
      `CHK({resp, rd}, {`RESP_OKAY, 32'h0000_00A5})
      axi_wr(`REG_STATUS, 32'hFFFF_FFFF);
      `CHK(resp, `RESP_OKAY)
      axi_rd(`REG_STATUS);
      `CHK(rd[1:0], `PWR_P0)
      axi_wr(32'h0000_0040, 32'h0000_0001);
      `CHK(resp, `RESP_SLVERR)
      axi_rd(32'h0000_0040);
      `CHK({resp, rd}, {`RESP_SLVERR, 32'h0000_0000})
      axi_wr(`REG_CTRL, `CTRL_RESET);
      u_usb3_serial_side_model.sense(3'b011);
      term <= 1'b1;
      repeat (5) @(negedge aclk);
      `CHK({sterm, pp, rxi}, 3'b111)
   endtask : regs_and_sense
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {aresetn, rq, txi, pol, eqt, term, oz, pd, txw, txf} = 0;
      {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = 0;
      {mismatches, tests_run, cycles} = 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      wait_phy();
      `CHK(n < 30, 1'b1)
      n = 0;
      repeat (20) @(negedge aclk) n += (pclk === 1'b1);
      `CHK(n > 0, 1'b1)
      regs_and_sense();
      rx_burst(1'b1, 1'b1, 1'b0, 1'b0);
      rx_burst(1'b0, 1'b0, 1'b0, 1'b1);
      loopback();
      lfps_idle();
      ones_zeros();
      set_power(`PWR_P1);
      set_power(`PWR_P2);
      detect(1'b1);
      detect(1'b0);
      set_power(`PWR_P3);
      `CHK(n, 60)
      repeat (10) @(negedge aclk) `CHK({pclk, phs}, 2'b00)
      final_report();
   end
endmodule : tb_usb3_pipe_phy_interface
`default_nettype wire
